/* rtl/pcsm_pkg.sv */
/*
 Constants and carrier types of the power manager.
 Assumes one 200 MHz clock.
*/
package pcsm_pkg;

    // Register byte offsets
    localparam logic [7:0] PCSM_CTRL_OFS = 8'h00;
    localparam logic [7:0] PCSM_SLEEP_OFS = 8'h01;
    localparam logic [7:0] PCSM_HUBMASK_OFS = 8'h14;
    localparam logic [7:0] PCSM_APBAMASK_OFS = 8'h18;
    localparam logic [7:0] PCSM_APBBMASK_OFS = 8'h1c;
    localparam logic [7:0] PCSM_APBCMASK_OFS = 8'h20;
    localparam logic [7:0] PCSM_FLAG_OFS = 8'h36;
    localparam logic [7:0] PCSM_CAUSE_OFS = 8'h38;
    localparam logic [7:0] PCSM_STATUS_OFS = 8'h3c;

    // Field positions
    localparam int PCSM_CTRL_FDEN_BIT = 2;
    localparam int PCSM_CTRL_BKUP_BIT = 4;
    localparam int PCSM_FLAG_CFAIL_BIT = 1;

    // Self and bridge mask bits
    localparam int PCSM_APBA_SELF_BIT = 1;
    localparam int PCSM_HUB_BRIDGE_A_BIT = 0;

    // Reset values
    localparam logic [31:0] PCSM_HUBMASK_RST = 32'h0000_001f;
    localparam logic [31:0] PCSM_APBAMASK_RST = 32'h0000_007f;
    localparam logic [31:0] PCSM_APBBMASK_RST = 32'h0000_001f;
    localparam logic [31:0] PCSM_APBCMASK_RST = 32'h0001_0000;

    // Reset cause bits
    localparam int PCSM_RC_POR = 0;
    localparam int PCSM_RC_BODC = 1;
    localparam int PCSM_RC_BODI = 2;
    localparam int PCSM_RC_EXT = 4;
    localparam int PCSM_RC_WDT = 5;
    localparam int PCSM_RC_SYS = 6;

    // Timing
    localparam int PCSM_CLK_NS = 5;
    localparam int PCSM_RST_HOLD_NS = 40;
    localparam int PCSM_RST_HOLD_CYC = (PCSM_RST_HOLD_NS + PCSM_CLK_NS - 1) / PCSM_CLK_NS;
    localparam int PCSM_WAKE_CYC = 4;

    typedef enum logic [2:0] {
        PCSM_ACTIVE,
        PCSM_IDLE0,
        PCSM_IDLE1,
        PCSM_IDLE2,
        PCSM_STANDBY,
        PCSM_WALK,
        PCSM_WAKE
    } pcsm_mode_t;

    typedef struct packed {
        logic por;
        logic bod_core;
        logic bod_io;
        logic ext;
        logic wdt;
        logic sys;
    } pcsm_rst_src_t;

    typedef struct packed {
        logic cpu_run;
        logic hub_run;
        logic apb_run;
        logic main_run;
        logic reg_lowpower;
        logic ram_lowpower;
    } pcsm_dom_t;

    typedef struct packed {
        logic power_rst;
        logic ext_rst;
        logic user_rst;
    } pcsm_rst_out_t;

endpackage : pcsm_pkg

/* rtl/pcsm_sync.sv */
/*
 Two flip-flop synchroniser.
 Assumes an async input.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsm_sync
    import pcsm_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pcsm_sync_st_t;

    pcsm_sync_st_t st_q;
    pcsm_sync_st_t st_d;

    always_comb
    begin
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sync_out = st_q.s2;
endmodule : pcsm_sync
`default_nettype wire

/* rtl/pcsm_clock_monitor.sv */
/*
 Main clock failure detector.
 Assumes async tick and reference inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsm_clock_monitor
    import pcsm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic monitor_en_in,
    // Observed clocks
    input wire logic main_tick_in,
    input wire logic ref_clk_in,
    // Result
    output logic fail_out
);
    typedef struct packed {
        logic tick_prev;
        logic ref_prev;
        logic seen;
        logic armed;
        logic fail;
    } pcsm_mon_st_t;

    pcsm_mon_st_t st_q;
    pcsm_mon_st_t st_d;
    logic [1:0] sync_w;

    pcsm_sync #(.W(2)) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({main_tick_in, ref_clk_in}),
        .sync_out(sync_w)
    );

    always_comb
    begin
        logic ref_rise;
        logic tick_edge;
        st_d = st_q;
        ref_rise = sync_w[0] & ~st_q.ref_prev;
        tick_edge = sync_w[1] ^ st_q.tick_prev;
        st_d.tick_prev = sync_w[1];
        st_d.ref_prev = sync_w[0];
        st_d.fail = 1'b0;
        if (!monitor_en_in)
        begin
            st_d.seen = 1'b0;
            st_d.armed = 1'b0;
        end
        else
        begin
            if (tick_edge)
                st_d.seen = 1'b1;
            if (ref_rise)
            begin
                // One full reference period without a main edge
                st_d.fail = st_q.armed & ~st_q.seen & ~tick_edge; // RULE6
                st_d.armed = 1'b1;
                st_d.seen = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign fail_out = st_q.fail;
endmodule : pcsm_clock_monitor
`default_nettype wire

/* rtl/pcsm_manager.sv */
/*
 Clock masks, failure fallback,
 reset cause and sleep sequencer.
 Assumes pins, reset sources and ticks
 are async; all else on sys_clk_in.
*/
// What this block does
// RULE1 - Mask bit low gates the peripheral clock.
// RULE2 - Masks reset to default enables.
// RULE3 - Gated bus clock blocks register access.
// RULE4 - One mask bit per clock domain.
// RULE5 - Own or bridge clock off locks masks.
// RULE6 - No main edge in a reference period is failure.
// RULE7 - Enable bit high keeps detector watching.
// RULE8 - Failure selects backup, sets flag, may interrupt.
// RULE9 - Failure sets backup select; zero reselects primary.
// RULE10 - Detector pauses at start-up and in sleep.
// RULE11 - Software keeps detector off in standby.
// RULE12 - Latest reset source is recorded.
// RULE13 - Reset scope depends on the reset kind.
// RULE14 - Low reset pin gives external reset.
// RULE15 - Software, watchdog and power sources reset.
// RULE16 - Wait instruction sleeps; deep bit and level choose mode.
// RULE17 - Idle levels stop CPU, hub, then bus clock.
// RULE18 - Each level wakes on its interrupt kinds.
// RULE19 - Standby stops unrequested sources; low-power regulator.
// RULE20 - Stopped domains halt whatever the masks say.
// RULE21 - Sleep-after-handler re-enters sleep on handler exit.
// RULE22 - Qualifying interrupt returns to active.
// RULE23 - Standby clock requests run without the CPU.
`timescale 1ns/1ps
`default_nettype none
module pcsm_manager
    import pcsm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Reset sources and pin
    input wire logic reset_pin_n_in,
    input wire logic por_in,
    input wire logic core_brownout_detect_in,
    input wire logic io_brownout_detect_in,
    input wire logic wdt_reset_in,
    input wire logic cpu_software_reset_request_in,
    output pcsm_rst_out_t reset_out,
    // CPU sleep control
    input wire logic wait_instruction_in,
    input wire logic handler_exit_in,
    input wire logic deep_sleep_select_in,
    input wire logic sleep_after_handler_in,
    input wire logic irq_sync_hub_in,
    input wire logic irq_sync_apb_in,
    input wire logic irq_async_in,
    // Clock sources
    input wire logic main_tick_in,
    input wire logic ref_clk_in,
    input wire logic main_clk_starting_in,
    input wire logic [7:0] keep_running_in_standby_in,
    input wire logic [7:0] request_driven_clock_in,
    input wire logic [7:0] clock_request_in,
    output logic [7:0] source_run_out,
    output logic backup_clock_select_out,
    output logic clock_failure_irq_out,
    // Clock enables and domain state
    output logic [31:0] hub_gate_out,
    output logic [31:0] apba_gate_out,
    output logic [31:0] apbb_gate_out,
    output logic [31:0] apbc_gate_out,
    output pcsm_dom_t domain_out
);
    typedef struct packed {
        pcsm_mode_t mode;
        logic [1:0] idle_level;
        logic fd_enable;
        logic bkup;
        logic fail_flag;
        logic fail_irq_en;
        logic [31:0] hub_mask;
        logic [31:0] apba_mask;
        logic [31:0] apbb_mask;
        logic [31:0] apbc_mask;
        logic [7:0] cause;
        logic [3:0] rst_cnt;
        pcsm_rst_out_t rst;
        logic [2:0] wake_cnt;
        logic [31:0] rdata;
    } pcsm_st_t;

    pcsm_st_t st_q;
    pcsm_st_t st_d;
    pcsm_rst_src_t src_w;
    logic fail_w;
    logic mon_en_w;
    logic lock_w;
    logic sleeping_w;
    logic [31:0] apb_gate_w;

    pcsm_sync #(.W(6)) u_rst_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({por_in, core_brownout_detect_in, io_brownout_detect_in, ~reset_pin_n_in,
                   wdt_reset_in, cpu_software_reset_request_in}),
        .sync_out(src_w)
    );

    pcsm_clock_monitor u_mon (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .monitor_en_in(mon_en_w),
        .main_tick_in(main_tick_in),
        .ref_clk_in(ref_clk_in),
        .fail_out(fail_w)
    );

    // Monitor gating
    assign sleeping_w = (st_q.mode != PCSM_ACTIVE);
    assign mon_en_w = st_q.fd_enable & ~sleeping_w & ~main_clk_starting_in; // RULE7 RULE10
    assign lock_w = ~st_q.apba_mask[PCSM_APBA_SELF_BIT] | ~st_q.hub_mask[PCSM_HUB_BRIDGE_A_BIT]; // RULE5
    assign apb_gate_w = {32{domain_out.apb_run}};

    always_comb
    begin
        pcsm_mode_t m;
        logic wr_ok;
        m = PCSM_ACTIVE;
        wr_ok = 1'b0;
        st_d = st_q;
        m = st_q.mode;
        st_d.rdata = '0;

        // Reset collection and stretch
        st_d.rst = '0;
        if (src_w.por | src_w.bod_core | src_w.bod_io | src_w.ext | src_w.wdt | src_w.sys) // RULE14 RULE15
        begin
            st_d.rst_cnt = 4'(PCSM_RST_HOLD_CYC);
            st_d.cause = '0; // RULE12
            if (src_w.por)
                st_d.cause[PCSM_RC_POR] = 1'b1;
            else if (src_w.bod_core)
                st_d.cause[PCSM_RC_BODC] = 1'b1;
            else if (src_w.bod_io)
                st_d.cause[PCSM_RC_BODI] = 1'b1;
            else if (src_w.ext)
                st_d.cause[PCSM_RC_EXT] = 1'b1;
            else if (src_w.wdt)
                st_d.cause[PCSM_RC_WDT] = 1'b1;
            else
                st_d.cause[PCSM_RC_SYS] = 1'b1;
        end
        else if (st_q.rst_cnt != 4'h0)
            st_d.rst_cnt = st_q.rst_cnt - 4'h1;
        if (st_d.rst_cnt != 4'h0)
        begin
            // Scope of each reset kind
            st_d.rst.power_rst = st_d.cause[PCSM_RC_POR] | st_d.cause[PCSM_RC_BODC]
                | st_d.cause[PCSM_RC_BODI]; // RULE13
            st_d.rst.ext_rst = st_d.rst.power_rst | st_d.cause[PCSM_RC_EXT]; // RULE13
            st_d.rst.user_rst = 1'b1; // RULE13
        end

        // Failure fallback
        if (fail_w)
        begin
            st_d.bkup = 1'b1; // RULE8 RULE9
            st_d.fail_flag = 1'b1; // RULE8
        end

        // Register writes
        wr_ok = reg_wr_in & domain_out.apb_run & st_q.apba_mask[PCSM_APBA_SELF_BIT]; // RULE3
        if (wr_ok)
        begin
            unique case (reg_addr_in)
                PCSM_CTRL_OFS:
                begin
                    st_d.fd_enable = reg_wdata_in[PCSM_CTRL_FDEN_BIT];
                    if (!fail_w)
                        st_d.bkup = reg_wdata_in[PCSM_CTRL_BKUP_BIT]; // RULE9
                end
                PCSM_SLEEP_OFS: st_d.idle_level = reg_wdata_in[1:0];
                PCSM_HUBMASK_OFS: if (!lock_w) st_d.hub_mask = reg_wdata_in; // RULE1 RULE4 RULE5
                PCSM_APBAMASK_OFS: if (!lock_w) st_d.apba_mask = reg_wdata_in; // RULE1 RULE5
                PCSM_APBBMASK_OFS: if (!lock_w) st_d.apbb_mask = reg_wdata_in; // RULE1 RULE5
                PCSM_APBCMASK_OFS: if (!lock_w) st_d.apbc_mask = reg_wdata_in; // RULE1 RULE5
                PCSM_FLAG_OFS:
                begin
                    if (reg_wdata_in[PCSM_FLAG_CFAIL_BIT] && !fail_w)
                        st_d.fail_flag = 1'b0;
                    st_d.fail_irq_en = reg_wdata_in[0];
                end
                default: ;
            endcase
        end

        // Register reads
        if (reg_rd_in && domain_out.apb_run && st_q.apba_mask[PCSM_APBA_SELF_BIT]) // RULE3
        begin
            unique case (reg_addr_in)
                PCSM_CTRL_OFS:
                begin
                    st_d.rdata[PCSM_CTRL_FDEN_BIT] = st_q.fd_enable;
                    st_d.rdata[PCSM_CTRL_BKUP_BIT] = st_q.bkup;
                end
                PCSM_SLEEP_OFS: st_d.rdata[1:0] = st_q.idle_level;
                PCSM_HUBMASK_OFS: st_d.rdata = st_q.hub_mask;
                PCSM_APBAMASK_OFS: st_d.rdata = st_q.apba_mask;
                PCSM_APBBMASK_OFS: st_d.rdata = st_q.apbb_mask;
                PCSM_APBCMASK_OFS: st_d.rdata = st_q.apbc_mask;
                PCSM_FLAG_OFS: st_d.rdata[1:0] = {st_q.fail_flag, st_q.fail_irq_en};
                PCSM_CAUSE_OFS: st_d.rdata[7:0] = st_q.cause; // RULE12
                PCSM_STATUS_OFS: st_d.rdata[2:0] = st_q.mode;
                default: st_d.rdata = '0;
            endcase
        end

        // Sleep sequencer
        unique case (st_q.mode)
            PCSM_ACTIVE:
                if (wait_instruction_in || (handler_exit_in && sleep_after_handler_in)) // RULE16 RULE21
                begin
                    if (deep_sleep_select_in)
                        m = PCSM_STANDBY; // RULE16
                    else if (st_q.idle_level == 2'h0)
                        m = PCSM_IDLE0;
                    else if (st_q.idle_level == 2'h1)
                        m = PCSM_IDLE1;
                    else
                        m = PCSM_IDLE2;
                end
            PCSM_IDLE0:
                if (irq_sync_hub_in || irq_sync_apb_in || irq_async_in) // RULE18 RULE22
                    m = PCSM_ACTIVE;
            PCSM_IDLE1:
                if (irq_sync_apb_in || irq_async_in) // RULE18 RULE22
                    m = PCSM_ACTIVE;
            PCSM_IDLE2:
                if (irq_async_in) // RULE18 RULE22
                    m = PCSM_ACTIVE;
            PCSM_STANDBY:
                if (irq_async_in) // RULE18
                    m = PCSM_WAKE;
                else if (|(clock_request_in & request_driven_clock_in)) // RULE23
                    m = PCSM_WALK;
            PCSM_WALK:
                if (irq_async_in) // RULE23
                    m = PCSM_WAKE;
                else if (!(|(clock_request_in & request_driven_clock_in)))
                    m = PCSM_STANDBY; // RULE23
            PCSM_WAKE:
                if (st_q.wake_cnt == 3'h0)
                    m = PCSM_ACTIVE;
            default: m = PCSM_ACTIVE;
        endcase
        st_d.wake_cnt = (m == PCSM_WAKE && st_q.mode != PCSM_WAKE) ? 3'(PCSM_WAKE_CYC - 1)
            : (st_q.wake_cnt != 3'h0 ? st_q.wake_cnt - 3'h1 : 3'h0);
        st_d.mode = m;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            st_q <= '0;
            st_q.mode <= PCSM_ACTIVE;
            st_q.hub_mask <= PCSM_HUBMASK_RST; // RULE2
            st_q.apba_mask <= PCSM_APBAMASK_RST; // RULE2
            st_q.apbb_mask <= PCSM_APBBMASK_RST; // RULE2
            st_q.apbc_mask <= PCSM_APBCMASK_RST; // RULE2
            st_q.cause <= 8'h01;
        end
        else
            st_q <= st_d;
    end

    // Domain policy
    always_comb
    begin
        domain_out = '0;
        domain_out.cpu_run = (st_q.mode == PCSM_ACTIVE); // RULE17
        domain_out.hub_run = (st_q.mode == PCSM_ACTIVE) || (st_q.mode == PCSM_IDLE0); // RULE17
        domain_out.apb_run = domain_out.hub_run || (st_q.mode == PCSM_IDLE1); // RULE17
        domain_out.main_run = (st_q.mode != PCSM_STANDBY); // RULE19
        domain_out.reg_lowpower = (st_q.mode == PCSM_STANDBY) || (st_q.mode == PCSM_WALK); // RULE19
        domain_out.ram_lowpower = domain_out.reg_lowpower; // RULE17 RULE19
    end

    // Source run policy
    always_comb
    begin
        if (st_q.mode == PCSM_STANDBY || st_q.mode == PCSM_WALK)
            source_run_out = keep_running_in_standby_in
                & (~request_driven_clock_in | clock_request_in); // RULE19 RULE23
        else
            source_run_out = ~request_driven_clock_in | clock_request_in;
    end

    // Gates
    assign hub_gate_out = st_q.hub_mask & {32{domain_out.hub_run}}; // RULE1 RULE20
    assign apba_gate_out = st_q.apba_mask & apb_gate_w; // RULE1 RULE20
    assign apbb_gate_out = st_q.apbb_mask & apb_gate_w; // RULE1 RULE20
    assign apbc_gate_out = st_q.apbc_mask & apb_gate_w; // RULE1 RULE20
    assign backup_clock_select_out = st_q.bkup; // RULE8
    assign clock_failure_irq_out = st_q.fail_flag & st_q.fail_irq_en; // RULE8
    assign reset_out = st_q.rst;
    assign reg_rdata_out = st_q.rdata;
endmodule : pcsm_manager
`default_nettype wire

/* sim/pcsm_clock_partner.sv */
/*
 Main clock tick and slow reference.
 Assumes the manager gates the main clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsm_clock_partner
    import pcsm_pkg::*;
#(
    parameter int MAIN_NS = 7,
    parameter int REF_NS = 400
)
(
    // Control
    input wire logic main_stop_in,
    input wire logic main_run_in,
    // Clocks
    output logic main_tick_out,
    output logic ref_clk_out
);
    initial
    begin
        main_tick_out = 1'b0;
        ref_clk_out = 1'b0;
    end
    // Stops in standby or on forced failure
    always #(MAIN_NS) if (!main_stop_in && main_run_in) main_tick_out = !main_tick_out;
    always #(REF_NS / 2) ref_clk_out = !ref_clk_out;
endmodule : pcsm_clock_partner
`default_nettype wire

/* sim/pcsm_manager_checker.sv */
/*
 Port checks of the manager.
 Bound into pcsm_manager; one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsm_manager_checker
    import pcsm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Watched inputs
    input wire logic reg_rd_in,
    input wire logic reset_pin_n_in,
    input wire logic wait_instruction_in,
    input wire logic deep_sleep_select_in,
    input wire logic irq_async_in,
    input wire logic [7:0] keep_running_in_standby_in,
    // Watched outputs
    input wire logic [31:0] reg_rdata_out,
    input wire pcsm_rst_out_t reset_out,
    input wire logic [7:0] source_run_out,
    input wire logic backup_clock_select_out,
    input wire logic [31:0] hub_gate_out,
    input wire logic [31:0] apba_gate_out,
    input wire pcsm_dom_t domain_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_sleep(deep);
        wait_instruction_in && domain_out.cpu_run && deep_sleep_select_in == deep;
    endsequence
    a_idle_entry: assert property (s_sleep(1'b0) |=> !domain_out.cpu_run && !domain_out.reg_lowpower)
        else $error("idle entry wrong");
    a_standby_entry: assert property (s_sleep(1'b1) |=> domain_out.reg_lowpower && domain_out.ram_lowpower
        && !domain_out.main_run) else $error("standby entry wrong");
    a_level_order: assert property (!domain_out.apb_run |-> !domain_out.hub_run && !domain_out.cpu_run)
        else $error("domain stop order wrong");
    a_gate_halted: assert property ((domain_out.apb_run || apba_gate_out == 32'h0)
        && (domain_out.hub_run || hub_gate_out == 32'h0)) else $error("gate open in stopped domain");
    a_idle2_deaf: assert property (s_sleep(1'b0) ##1 (!domain_out.apb_run && !irq_async_in)
        |=> !domain_out.cpu_run) else $error("idle 2 woke without async irq");
    a_standby_sources: assert property (domain_out.reg_lowpower
        |-> (source_run_out & ~keep_running_in_standby_in) == 8'h0) else $error("source runs in standby");
    a_standby_wake: assert property (domain_out.reg_lowpower && irq_async_in |-> ##[1:8] domain_out.cpu_run)
        else $error("no wake from standby");
    a_rdata_quiet: assert property (!reg_rd_in || !domain_out.apb_run |=> reg_rdata_out == 32'h0)
        else $error("read data without access");
    a_pin_reset: assert property (!reset_pin_n_in [*5] |-> reset_out.ext_rst && reset_out.user_rst)
        else $error("pin reset missing");
    a_sleep_no_fail: assert property (!domain_out.cpu_run [*3] |-> !$rose(backup_clock_select_out))
        else $error("failure detected in sleep");
endmodule : pcsm_manager_checker
bind pcsm_manager pcsm_manager_checker u_checker (.sys_clk_in, .rst_n_in, .reg_rd_in, .reset_pin_n_in,
    .wait_instruction_in, .deep_sleep_select_in, .irq_async_in, .keep_running_in_standby_in, .reg_rdata_out,
    .reset_out, .source_run_out, .backup_clock_select_out, .hub_gate_out, .apba_gate_out, .domain_out);
`default_nettype wire

/* sim/power_clock_sleep_manager_test.sv */
/*
 Bench of the power manager.
 Assumes the clock partner and bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module power_clock_sleep_manager_test
    import pcsm_pkg::*;
();
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h0, keep_running_in_standby_in = 8'h0;
    logic [7:0] request_driven_clock_in = 8'h0, clock_request_in = 8'h0, source_run_out;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, hub_gate_out, apba_gate_out, apbb_gate_out, apbc_gate_out;
    logic [5:0] src = 6'h0;
    wire logic reset_pin_n_in, por_in, core_brownout_detect_in, io_brownout_detect_in;
    wire logic wdt_reset_in, cpu_software_reset_request_in, main_tick_in, ref_clk_in;
    logic wait_instruction_in = 1'b0, handler_exit_in = 1'b0, deep_sleep_select_in = 1'b0;
    logic sleep_after_handler_in = 1'b0, irq_sync_hub_in = 1'b0, irq_sync_apb_in = 1'b0, irq_async_in = 1'b0;
    logic main_clk_starting_in = 1'b0, main_stop = 1'b0, backup_clock_select_out, clock_failure_irq_out;
    pcsm_rst_out_t reset_out;
    pcsm_dom_t domain_out;
    int miscompares = 0, samples_checked = 0;
    logic [31:0] st = 32'h5, v, m[4];
    assign {cpu_software_reset_request_in, wdt_reset_in, reset_pin_n_in, io_brownout_detect_in,
        core_brownout_detect_in, por_in} = src ^ 6'h08;
    always #(PCSM_CLK_NS / 2.0) sys_clk_in = !sys_clk_in;
    pcsm_manager dut (.*);
    pcsm_clock_partner u_clk (.main_stop_in(main_stop), .main_run_in(domain_out.main_run),
        .main_tick_out(main_tick_in), .ref_clk_out(ref_clk_in));
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : xs
    function automatic logic [7:0] ofs(input int i);
        return 8'h14 + 8'(4 * i);
    endfunction : ofs
    function automatic logic [31:0] gate(input int i);
        return i == 0 ? hub_gate_out : i == 1 ? apba_gate_out : i == 2 ? apbb_gate_out : apbc_gate_out;
    endfunction : gate
    task automatic final_report();
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask : rchk
    task automatic pulse(input bit h);
        @(posedge sys_clk_in);
        handler_exit_in <= h;
        wait_instruction_in <= !h;
        @(posedge sys_clk_in);
        handler_exit_in <= 1'b0;
        wait_instruction_in <= 1'b0;
        #1;
    endtask : pulse
    task automatic wake();
        @(posedge sys_clk_in);
        irq_async_in <= 1'b1;
        cyc(1);
        for (int n = 0; n < 12 && domain_out.cpu_run !== 1'b1; n++) cyc(1);
        @(posedge sys_clk_in);
        irq_async_in <= 1'b0;
        #1;
        chk(domain_out.cpu_run, 1'b1);
    endtask : wake
    initial
    begin
        #100000;
        miscompares++;
        final_report();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        cyc(3);
        m = '{PCSM_HUBMASK_RST, PCSM_APBAMASK_RST, PCSM_APBBMASK_RST, PCSM_APBCMASK_RST};
        for (int i = 0; i < 4; i++) rchk(ofs(i), m[i]);
        rchk(PCSM_CAUSE_OFS, 32'h1);
        rchk(8'h40, 32'h0);
        // Random masks, self and bridge on
        repeat (6) for (int i = 0; i < 4; i++)
        begin
            v = xs() | (i == 0 ? 32'h1 : i == 1 ? 32'h2 : 32'h0);
            wr(ofs(i), v);
            m[i] = v;
            chk(gate(i), v);
            rchk(ofs(i), v);
        end
        // Idle levels
        for (int l = 0; l < 3; l++)
        begin
            wr(PCSM_SLEEP_OFS, 32'(l));
            pulse(1'b0);
            chk(domain_out, {1'b0, l == 0, l < 2, 1'b1, 2'b00});
            chk(hub_gate_out, l > 0 ? 32'h0 : m[0]);
            chk(apba_gate_out, l == 2 ? 32'h0 : m[1]);
            rchk(PCSM_STATUS_OFS, l < 2 ? 32'(l + 1) : 32'h0);
            for (int k = 0; k < 3; k++)
            begin
                @(posedge sys_clk_in);
                {irq_async_in, irq_sync_apb_in, irq_sync_hub_in} <= 3'b1 << k;
                cyc(1);
                chk(domain_out.cpu_run, l <= k);
            end
            @(posedge sys_clk_in);
            {irq_async_in, irq_sync_apb_in, irq_sync_hub_in} <= 3'b0;
        end
        for (int s = 0; s < 2; s++)
        begin
            sleep_after_handler_in <= s[0];
            pulse(1'b1);
            chk(domain_out.cpu_run, !s[0]);
            wake();
        end
        // Standby with clock requests
        sleep_after_handler_in <= 1'b0;
        keep_running_in_standby_in <= 8'(xs()) | 8'h01;
        request_driven_clock_in <= 8'(xs()) | 8'h01;
        deep_sleep_select_in <= 1'b1;
        pulse(1'b0);
        chk(domain_out, 6'h03);
        chk(source_run_out, keep_running_in_standby_in & ~request_driven_clock_in);
        clock_request_in <= 8'h01;
        cyc(4);
        chk({domain_out.cpu_run, source_run_out[0]}, 2'b01);
        clock_request_in <= 8'h00;
        cyc(4);
        chk(domain_out.reg_lowpower, 1'b1);
        deep_sleep_select_in <= 1'b0;
        wake();
        // Clock failure
        wr(PCSM_CTRL_OFS, 32'h1 << PCSM_CTRL_FDEN_BIT);
        wr(PCSM_FLAG_OFS, 32'h1);
        cyc(200);
        chk(backup_clock_select_out, 1'b0);
        main_stop <= 1'b1;
        for (int n = 0; n < 300 && backup_clock_select_out !== 1'b1; n++) @(posedge sys_clk_in);
        #1;
        chk({backup_clock_select_out, clock_failure_irq_out}, 2'b11);
        rchk(PCSM_FLAG_OFS, 32'h3);
        main_stop <= 1'b0;
        cyc(20);
        wr(PCSM_CTRL_OFS, 32'h1 << PCSM_CTRL_FDEN_BIT);
        chk({backup_clock_select_out, clock_failure_irq_out}, 2'b01);
        wr(PCSM_FLAG_OFS, 32'h3);
        chk(clock_failure_irq_out, 1'b0);
        wr(PCSM_CTRL_OFS, 32'h0);
        // Reset sources
        for (int i = 0; i < 6; i++)
        begin
            src <= 6'h1 << i;
            cyc(5);
            chk(reset_out, i < 3 ? 3'b111 : i == 3 ? 3'b011 : 3'b001);
            src <= 6'h0;
            cyc(14);
            chk(reset_out, 3'b000);
            rchk(PCSM_CAUSE_OFS, 32'h1 << (i < 3 ? i : i + 1));
        end
        // Self gating locks masks
        wr(ofs(1), 32'h0);
        chk(apba_gate_out, 32'h0);
        rchk(ofs(1), 32'h0);
        wr(ofs(1), PCSM_APBAMASK_RST);
        wr(ofs(3), 32'hffff_ffff);
        chk({apba_gate_out, apbc_gate_out}, {32'h0, m[3]});
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        cyc(3);
        chk(apba_gate_out, PCSM_APBAMASK_RST);
        final_report();
    end
endmodule : power_clock_sleep_manager_test
`default_nettype wire
